// ==== verilog/gdfc_top.v ====
// control logic of a high-side gate driver with overcurrent sequencing
`timescale 1ns/10ps
`default_nettype none
`include "gdfc_defines.vh"

module gdfc_top #(
    parameter RETRY_CYCLES = `GDFC_RETRY_CYCLES,
    parameter FLT_DEASSERT_CYC = `GDFC_FLT_DEASSERT_CYC
) (
    input wire clk,
    input wire resetn,
    input wire shutdown_ctl_n,
    input wire supply_in_ok,
    input wire main_switch_cmd,
    input wire precharge_cmd,
    input wire latch_off_mode,
    input wire rail_above_uvlo_rise,
    input wire rail_above_uvlo_fall,
    input wire rail_at_pump_high,
    input wire rail_above_pump_low,
    input wire oc_sense_over,
    input wire sc_sense_over,
    input wire timer_at_warn,
    input wire timer_at_oc,
    input wire timer_above_low,
    output reg charge_pump_on,
    output reg driver_active,
    output reg source_drive_out,
    output reg sink_drive_out,
    output reg precharge_source_out,
    output reg precharge_sink_out,
    output reg timer_charge_strong,
    output reg timer_charge_weak,
    output reg timer_discharge_weak,
    output reg timer_discharge_fast,
    output reg overcurrent_fault_n
);

    // ------------------------------------------------------------
    // protection states
    // ------------------------------------------------------------
    localparam [5:0] ST_RUN = 6'h01;
    localparam [5:0] ST_OC_TIME = 6'h02;
    localparam [5:0] ST_RETRY_DIS = 6'h04;
    localparam [5:0] ST_RETRY_CHG = 6'h08;
    localparam [5:0] ST_LATCHED = 6'h10;
    localparam [5:0] ST_CMD_WAIT = 6'h20;

    // parameters are 32-bit integers; keep only the counter widths on purpose
    localparam integer RETRY_LAST_I = RETRY_CYCLES - 1;
    localparam integer DLY_COUNT_I = FLT_DEASSERT_CYC;
    localparam [`GDFC_RETRY_CNT_W-1:0] RETRY_LAST = RETRY_LAST_I[`GDFC_RETRY_CNT_W-1:0];
    localparam [`GDFC_DLY_CNT_W-1:0] DLY_COUNT = DLY_COUNT_I[`GDFC_DLY_CNT_W-1:0];

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    wire [`GDFC_PIN_W-1:0] pins_raw;
    wire [`GDFC_PIN_W-1:0] pins;
    wire en_s;
    wire main_s;
    wire pre_s;
    wire latch_mode_s;
    wire por_ok_s;

    assign pins_raw = {supply_in_ok, latch_off_mode, precharge_cmd, main_switch_cmd,
                       shutdown_ctl_n};

    gdfc_sync #(
        .WIDTH(`GDFC_PIN_W),
        .RESET_VAL({`GDFC_PIN_W{1'b0}})
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .d(pins_raw),
        .q(pins)
    );

    assign en_s = pins[`GDFC_PIN_EN];
    assign main_s = pins[`GDFC_PIN_MAIN];
    assign pre_s = pins[`GDFC_PIN_PRE];
    assign latch_mode_s = pins[`GDFC_PIN_LATCH];
    assign por_ok_s = pins[`GDFC_PIN_POR];

    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------
    reg [5:0] state_r;
    reg [5:0] state_nxt;
    reg [`GDFC_RETRY_CNT_W-1:0] retry_cnt_r;
    reg [`GDFC_RETRY_CNT_W-1:0] retry_cnt_nxt;
    reg uvlo_ok_r;
    reg uvlo_ok_nxt;
    reg pump_nxt;
    reg main_prev_r;
    reg flt_nxt;
    reg dly_start;
    wire dly_busy;
    wire active;
    wire powered;
    wire main_fall;

    // shutdown or supply loss both put the whole block at rest
    assign powered = en_s & por_ok_s;
    assign active = powered & uvlo_ok_r;
    // latch clears on command low edge or whenever the command is low
    assign main_fall = main_prev_r & ~main_s;

    // ------------------------------------------------------------
    // boost lockout with hysteresis and pump regulation
    // ------------------------------------------------------------
    always @* begin
        uvlo_ok_nxt = uvlo_ok_r;
        if (!powered) begin
            uvlo_ok_nxt = 1'b0;
        end else if (rail_above_uvlo_rise) begin
            uvlo_ok_nxt = 1'b1;
        end else if (!rail_above_uvlo_fall) begin
            uvlo_ok_nxt = 1'b0;
        end
    end

    always @* begin
        pump_nxt = charge_pump_on;
        if (!powered) begin
            pump_nxt = 1'b0;
        end else if (rail_at_pump_high) begin
            pump_nxt = 1'b0;
        end else if (!rail_above_pump_low) begin
            pump_nxt = 1'b1;
        end else if (!charge_pump_on && !rail_above_uvlo_rise) begin
            // coming out of shutdown the rail sits between levels: start pumping
            pump_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // fault flag release delay
    // ------------------------------------------------------------
    gdfc_dly #(
        .CNT_W(`GDFC_DLY_CNT_W),
        .COUNT(DLY_COUNT)
    ) u_flt_dly (
        .clk(clk),
        .resetn(resetn),
        .start(dly_start),
        .cancel(~active),
        .busy(dly_busy)
    );

    // ------------------------------------------------------------
    // overcurrent / short-circuit sequencer
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        retry_cnt_nxt = retry_cnt_r;
        dly_start = 1'b0;
        if (!active) begin
            state_nxt = ST_RUN;
            retry_cnt_nxt = {`GDFC_RETRY_CNT_W{1'b0}};
        end else begin
            case (state_r)
            ST_RUN: begin
                // fixed fast short path bypasses the timer
                if (sc_sense_over) begin
                    state_nxt = latch_mode_s ? ST_LATCHED : ST_RETRY_DIS;
                    retry_cnt_nxt = {`GDFC_RETRY_CNT_W{1'b0}};
                end else if (oc_sense_over) begin
                    state_nxt = ST_OC_TIME;
                end
            end
            ST_OC_TIME: begin
                if (sc_sense_over || timer_at_oc) begin
                    // turn-off at overcurrent level or on a short: latch in latch mode, else retry
                    state_nxt = latch_mode_s ? ST_LATCHED : ST_RETRY_DIS;
                    retry_cnt_nxt = {`GDFC_RETRY_CNT_W{1'b0}};
                end else if (!oc_sense_over) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RETRY_DIS: begin
                // slow discharge down to low level
                if (!timer_above_low) begin
                    state_nxt = ST_RETRY_CHG;
                end
            end
            ST_RETRY_CHG: begin
                if (timer_at_oc) begin
                    if (retry_cnt_r == RETRY_LAST) begin
                        // turn back on, flag held for release delay
                        state_nxt = ST_RUN;
                        retry_cnt_nxt = {`GDFC_RETRY_CNT_W{1'b0}};
                        dly_start = 1'b1;
                    end else begin
                        state_nxt = ST_RETRY_DIS;
                        retry_cnt_nxt = retry_cnt_r + {{(`GDFC_RETRY_CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            ST_LATCHED: begin
                // held off; cleared whenever the command is low
                if (main_fall || !main_s) begin
                    state_nxt = ST_CMD_WAIT;
                    retry_cnt_nxt = {`GDFC_RETRY_CNT_W{1'b0}};
                end
            end
            ST_CMD_WAIT: begin
                // latch reset done; pull-up only follows a fresh high command
                if (main_s) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault flag
    // ------------------------------------------------------------
    always @* begin
        flt_nxt = 1'b1;
        if (active) begin
            case (state_nxt)
            // warning once timer reaches warn level
            ST_OC_TIME: flt_nxt = ~timer_at_warn;
            // short asserts flag with the turn-off
            ST_RETRY_DIS: flt_nxt = 1'b0;
            ST_RETRY_CHG: flt_nxt = 1'b0;
            ST_LATCHED: flt_nxt = 1'b0;
            ST_RUN: flt_nxt = ~(dly_start | dly_busy);
            default: flt_nxt = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers and drive outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_RUN;
            retry_cnt_r <= {`GDFC_RETRY_CNT_W{1'b0}};
            uvlo_ok_r <= 1'b0;
            main_prev_r <= 1'b0;
            charge_pump_on <= 1'b0;
            driver_active <= 1'b0;
            source_drive_out <= 1'b0;
            sink_drive_out <= 1'b1;
            precharge_source_out <= 1'b0;
            precharge_sink_out <= 1'b1;
            timer_charge_strong <= 1'b0;
            timer_charge_weak <= 1'b0;
            timer_discharge_weak <= 1'b0;
            timer_discharge_fast <= 1'b1;
            overcurrent_fault_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
            retry_cnt_r <= retry_cnt_nxt;
            uvlo_ok_r <= uvlo_ok_nxt;
            main_prev_r <= main_s;
            charge_pump_on <= pump_nxt;
            driver_active <= active;
            // pull-up when commanded and no fault holds the switch off
            source_drive_out <= active & main_s & ((state_nxt == ST_RUN) |
                                                   (state_nxt == ST_OC_TIME));
            // pulldown whenever the pull-up is not driving
            sink_drive_out <= ~(active & main_s & ((state_nxt == ST_RUN) |
                                                   (state_nxt == ST_OC_TIME)));
            // precharge source current, untouched by faults
            precharge_source_out <= active & pre_s;
            // strong pulldown when command low or shut down
            precharge_sink_out <= ~(active & pre_s);
            // strong timer charge while timing overcurrent
            timer_charge_strong <= active & (state_nxt == ST_OC_TIME);
            timer_charge_weak <= active & (state_nxt == ST_RETRY_CHG);
            timer_discharge_weak <= active & (state_nxt == ST_RETRY_DIS);
            // fast discharge when idle, latched or latch cleared
            timer_discharge_fast <= ~active | (state_nxt == ST_RUN) |
                                    (state_nxt == ST_LATCHED) | (state_nxt == ST_CMD_WAIT);
            overcurrent_fault_n <= flt_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== include/gdfc_defines.vh ====
// constants for the gate drive fault controller
`ifndef GDFC_DEFINES_VH
`define GDFC_DEFINES_VH

// clock
`define GDFC_CLK_PERIOD_NS 10

// retry sequencing
`define GDFC_RETRY_CYCLES 32
`define GDFC_RETRY_CNT_W 6

// fault flag release delay after retry turn-on
`define GDFC_FLT_DEASSERT_NS 260000
`define GDFC_FLT_DEASSERT_CYC \
    ((`GDFC_FLT_DEASSERT_NS + `GDFC_CLK_PERIOD_NS - 1) / `GDFC_CLK_PERIOD_NS)
`define GDFC_DLY_CNT_W 16

// longest short-circuit response, cycles rounded down
`define GDFC_SC_RESP_NS 1200
`define GDFC_SC_RESP_CYC (`GDFC_SC_RESP_NS / `GDFC_CLK_PERIOD_NS)

// bit positions inside the synchronised pin group
`define GDFC_PIN_W 5
`define GDFC_PIN_EN 0
`define GDFC_PIN_MAIN 1
`define GDFC_PIN_PRE 2
`define GDFC_PIN_LATCH 3
`define GDFC_PIN_POR 4

`endif

// ==== verilog/gdfc_sync.v ====
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module gdfc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_r;

    // meta_r feeds only q; nothing else may look at it
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/gdfc_dly.v ====
// retriggerable one-shot delay counter
`timescale 1ns/10ps
`default_nettype none

module gdfc_dly #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] COUNT = {{(CNT_W-1){1'b0}}, 1'b1}
) (
    input wire clk,
    input wire resetn,
    input wire start,
    input wire cancel,
    output wire busy
);

    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;

    assign busy = (cnt_r != {CNT_W{1'b0}});

    always @* begin
        cnt_nxt = cnt_r;
        if (cancel) begin
            cnt_nxt = {CNT_W{1'b0}};
        end else if (start) begin
            cnt_nxt = COUNT;
        end else if (busy) begin
            cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== bench/gdfc_checker.sv ====
// port-level assertion checker for the gate drive fault controller
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module gdfc_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rail_above_uvlo_rise,
    input wire logic rail_above_uvlo_fall,
    input wire logic rail_at_pump_high,
    input wire logic oc_sense_over,
    input wire logic sc_sense_over,
    input wire logic timer_at_warn,
    input wire logic timer_at_oc,
    input wire logic charge_pump_on,
    input wire logic driver_active,
    input wire logic source_drive_out,
    input wire logic sink_drive_out,
    input wire logic precharge_source_out,
    input wire logic precharge_sink_out,
    input wire logic timer_charge_strong,
    input wire logic timer_charge_weak,
    input wire logic timer_discharge_fast,
    input wire logic overcurrent_fault_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_idle_gate_off:
        assert property (!driver_active [*2] |-> !source_drive_out)
        else $error("gate on while inactive");
    chk_main_pair:
        assert property (sink_drive_out == !source_drive_out)
        else $error("main drive pair clash");
    chk_pre_pair:
        assert property (precharge_sink_out == !precharge_source_out)
        else $error("precharge drive pair clash");
    chk_uvlo_rise:
        assert property ($rose(driver_active) |-> $past(rail_above_uvlo_rise))
        else $error("driver active below lockout");
    // lockout state and driver enable are two register stages deep
    chk_uvlo_fall:
        assert property (driver_active && !rail_above_uvlo_fall |-> ##2 !driver_active)
        else $error("driver kept active below falling level");
    chk_pump_stop:
        assert property (rail_at_pump_high |=> !charge_pump_on)
        else $error("pump on at upper level");
    chk_oc_warn:
        assert property (timer_charge_strong && oc_sense_over && timer_at_warn
            |=> !overcurrent_fault_n)
        else $error("no warning at timer level");
    chk_oc_trip:
        assert property (timer_charge_strong && oc_sense_over && timer_at_oc
            |=> !source_drive_out)
        else $error("gate kept on at trip level");
    chk_sc_trip:
        assert property (source_drive_out && sc_sense_over
            |=> !source_drive_out && !overcurrent_fault_n)
        else $error("slow short response");
    chk_oc_pulse:
        assert property (timer_charge_strong && !oc_sense_over && !timer_at_oc
            && !sc_sense_over |=> timer_discharge_fast && source_drive_out)
        else $error("short overcurrent pulse mishandled");

    cover property (timer_charge_weak);
    cover property ($rose(source_drive_out) && !overcurrent_fault_n);
    cover property (source_drive_out && sc_sense_over);
endmodule
// ------------------------------------------------------------
// attach
// ------------------------------------------------------------
bind gdfc_top gdfc_checker chk_u (.*);
`default_nettype wire

// ==== bench/gdfc_host.sv ====
// host controller model driving the two gate commands
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// host
// ------------------------------------------------------------
module gdfc_host (
    input wire logic clk,
    input wire logic want_pre,
    input wire logic want_main,
    output logic main_switch_cmd,
    output logic precharge_cmd
);
    // precharge before main
    // main waits a cycle for precharge to drop, so the two never overlap
    always @(posedge clk) begin
        precharge_cmd <= want_pre && !want_main && !main_switch_cmd;
        main_switch_cmd <= want_main && !precharge_cmd;
    end
endmodule
`default_nettype wire

// ==== bench/test_gate_drive_fault_controller.sv ====
// self-checking bench for the gate drive fault controller
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module test_gate_drive_fault_controller;
    localparam int RC = 3;
    localparam int FD = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic shutdown_ctl_n = 1'b0, supply_in_ok = 1'b0, latch_off_mode = 1'b0;
    logic rail_above_uvlo_rise = 1'b0, rail_above_uvlo_fall = 1'b0;
    logic rail_at_pump_high = 1'b0, rail_above_pump_low = 1'b0;
    logic oc_sense_over = 1'b0, sc_sense_over = 1'b0, timer_above_low = 1'b0;
    logic timer_at_warn = 1'b0, timer_at_oc = 1'b0, want_pre = 1'b0, want_main = 1'b0;
    logic main_switch_cmd, precharge_cmd, charge_pump_on, driver_active;
    logic source_drive_out, sink_drive_out, precharge_source_out, precharge_sink_out;
    logic timer_charge_strong, timer_charge_weak, timer_discharge_weak;
    logic timer_discharge_fast, overcurrent_fault_n;
    int n_fail = 0;
    int check_count = 0;

    always #5 clk = ~clk;

    // short retry and release counts keep the run brief
    gdfc_top #(.RETRY_CYCLES(RC), .FLT_DEASSERT_CYC(FD)) dut_u (.*);
    gdfc_host host_u (.*);

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // timer falls to its low level, climbs to trip level: one retry cycle
    task automatic tmr_cycles(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) timer_above_low <= 1'b0;
            step(2);
            chk("weak", !latch_off_mode, timer_charge_weak);
            @(posedge clk) begin
                timer_above_low <= 1'b1;
                timer_at_oc <= 1'b1;
            end
            @(posedge clk) timer_at_oc <= 1'b0;
        end
    endtask

    task automatic trip(input logic sc);
        @(posedge clk) begin
            timer_above_low <= 1'b1;
            sc_sense_over <= sc;
            oc_sense_over <= !sc;
            timer_at_warn <= !sc;
            timer_at_oc <= !sc;
        end
        step(4);
        chk("gate", 1'b0, source_drive_out);
        chk("sink", 1'b1, sink_drive_out);
        chk("flag", 1'b0, overcurrent_fault_n);
        chk("pre", 1'b0, precharge_source_out);
        @(posedge clk) begin
            sc_sense_over <= 1'b0;
            oc_sense_over <= 1'b0;
            timer_at_warn <= 1'b0;
            timer_at_oc <= 1'b0;
        end
    endtask

    task automatic t_power();
        @(posedge clk) begin
            shutdown_ctl_n <= 1'b1;
            supply_in_ok <= 1'b1;
            want_main <= 1'b1;
        end
        step(8);
        chk("active", 1'b0, driver_active);
        chk("gate", 1'b0, source_drive_out);
        chk("pump", 1'b1, charge_pump_on);
        @(posedge clk) begin
            rail_above_uvlo_rise <= 1'b1;
            rail_above_uvlo_fall <= 1'b1;
            rail_above_pump_low <= 1'b1;
        end
        step(2);
        chk("active", 1'b1, driver_active);
        step(2);
        chk("gate", 1'b1, source_drive_out);
        @(posedge clk) rail_at_pump_high <= 1'b1;
        step(2);
        chk("pump", 1'b0, charge_pump_on);
        @(posedge clk) rail_at_pump_high <= 1'b0;
        step(2);
        chk("pump", 1'b0, charge_pump_on);
        @(posedge clk) rail_above_pump_low <= 1'b0;
        step(2);
        chk("pump", 1'b1, charge_pump_on);
        @(posedge clk) begin
            rail_above_pump_low <= 1'b1;
            rail_above_uvlo_rise <= 1'b0;
        end
        step(4);
        chk("active", 1'b1, driver_active);
        @(posedge clk) rail_above_uvlo_fall <= 1'b0;
        step(2);
        chk("active", 1'b0, driver_active);
        @(posedge clk) begin
            want_main <= 1'b0;
            rail_above_uvlo_rise <= 1'b1;
            rail_above_uvlo_fall <= 1'b1;
        end
        step(6);
    endtask

    task automatic t_pre();
        @(posedge clk) want_pre <= 1'b1;
        step(6);
        chk("pre", 1'b1, precharge_source_out);
        @(posedge clk) begin
            want_pre <= 1'b0;
            want_main <= 1'b1;
        end
        step(8);
        chk("pre_sink", 1'b1, precharge_sink_out);
        chk("gate", 1'b1, source_drive_out);
    endtask

    task automatic t_oc_pulse();
        @(posedge clk) oc_sense_over <= 1'b1;
        step(2);
        chk("strong", 1'b1, timer_charge_strong);
        @(posedge clk) timer_at_warn <= 1'b1;
        step(2);
        chk("flag", 1'b0, overcurrent_fault_n);
        @(posedge clk) begin
            oc_sense_over <= 1'b0;
            timer_at_warn <= 1'b0;
        end
        step(2);
        chk("gate", 1'b1, source_drive_out);
        chk("fast", 1'b1, timer_discharge_fast);
    endtask

    task automatic t_retry(input logic sc);
        int n;
        trip(sc);
        step(1);
        chk("weak_dis", 1'b1, timer_discharge_weak);
        tmr_cycles(RC - 1);
        step(2);
        chk("gate", 1'b0, source_drive_out);
        tmr_cycles(1);
        step(2);
        chk("gate", 1'b1, source_drive_out);
        n = 0;
        while (overcurrent_fault_n !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n >= 40) begin
            n_fail++;
            complete_run();
        end
        chk("flag_delay", 1'b1, n >= FD - 4 && n <= FD + 2);
        @(posedge clk) timer_above_low <= 1'b0;
    endtask

    task automatic t_latch();
        @(posedge clk) latch_off_mode <= 1'b1;
        step(3);
        trip(1'b0);
        tmr_cycles(RC + 1);
        step(2);
        chk("gate", 1'b0, source_drive_out);
        @(posedge clk) want_main <= 1'b0;
        step(6);
        chk("flag", 1'b1, overcurrent_fault_n);
        @(posedge clk) want_main <= 1'b1;
        step(6);
        chk("gate", 1'b1, source_drive_out);
    endtask

    task automatic t_shutdown();
        @(posedge clk) shutdown_ctl_n <= 1'b0;
        step(5);
        chk("active", 1'b0, driver_active);
        chk("gate", 1'b0, source_drive_out);
        chk("pump", 1'b0, charge_pump_on);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_power();
        t_pre();
        t_oc_pulse();
        t_retry(1'b0);
        t_retry(1'b1);
        t_latch();
        t_shutdown();
        complete_run();
    end
endmodule
`default_nettype wire
